// >>> rtl/ofs_consts.svh
// Constants for the one-time-programmable overlay sequencer.
`ifndef OFS_CONSTS_SVH
`define OFS_CONSTS_SVH
`define OFS_CMD_ENTRY     16'h0088
`define OFS_CMD_SETUP     16'h0025
`define OFS_CMD_COMMIT    16'h0029
`define OFS_CMD_EXIT      16'h00F0
`define OFS_OFF_UNLOCK    12'h555
`define OFS_OFF_COUNT     12'h2AA
`define OFS_MAX_WORDS     6'd32
`define OFS_T_ACC_NS      80
`define OFS_T_SLEEP_EXTRA_NS 20
`define OFS_CLK_NS        25
`define OFS_ACC_CYC       ((`OFS_T_ACC_NS + `OFS_CLK_NS - 1) / `OFS_CLK_NS)
`define OFS_SLEEP_CYC     ((`OFS_T_ACC_NS + `OFS_T_SLEEP_EXTRA_NS + `OFS_CLK_NS - 1) / `OFS_CLK_NS)
`define OFS_PROG_CYC      8
`define OFS_WRAP_MASK     8'hFF
`endif

// >>> rtl/ofs_pkg.sv
// Types shared by the overlay sequencer.
package ofs_pkg;
   typedef enum logic [2:0] {
      OFS_IDLE, OFS_OVL, OFS_CNT, OFS_LOAD, OFS_COMMIT, OFS_BUSY
   } ofs_state_t;
   typedef struct packed {
      logic        we;
      logic [23:0] addr;
      logic [15:0] data;
   } ofs_wr_t;
   typedef struct packed {
      logic [15:0] dout;
      logic [15:0] doe;
   } ofs_dq_t;
endpackage : ofs_pkg

// >>> rtl/ofs_sync2.sv
// Two-flop synchroniser for a bus of pin inputs.
`timescale 1ns/1ps
`default_nettype none
module ofs_sync2 #(parameter int W = 1) (
   // Clock and reset
   input  wire logic         sys_clk,
   input  wire logic         srst,
   // Data
   input  wire logic [W-1:0] din,
   output logic [W-1:0]      dout
);
   logic [W-1:0] meta_q;
   always_ff @(posedge sys_clk) begin
      if (srst) begin
         meta_q <= '0;
         dout   <= '0;
      end else begin
         meta_q <= din;
         dout   <= meta_q;
      end
   end
endmodule : ofs_sync2
`default_nettype wire

// >>> rtl/ofs_seq.sv
// Overlay command sequencer with standby, sleep and output-disable control.
`timescale 1ns/1ps
`default_nettype none
`include "ofs_consts.svh"
module ofs_seq (
   // Clock and reset
   input  wire logic             sys_clk,
   input  wire logic             srst,
   // Flash pins (active-low strobes)
   input  wire logic             ce_n,
   input  wire logic             oe_n,
   input  wire logic             we_n,
   input  wire logic             reset_n,
   input  wire logic             sync_mode,
   input  wire logic             suspended,
   input  wire logic             burst_step,
   input  wire logic [23:0]      addr_pin,
   input  wire logic [15:0]      data_pins_i,
   output logic [15:0]           data_pins_o,
   output logic [15:0]           data_pins_oe,
   output logic                  ready,
   // Array side, same clock
   input  wire logic [15:0]      array_rdata,
   input  wire logic [15:0]      overlay_rdata,
   input  wire logic             cust_locked,
   output ofs_pkg::ofs_wr_t      prog_wr,
   output logic                  overlay_active,
   output logic [7:0]            overlay_addr,
   output logic                  protect_err,
   output logic                  sleeping,
   output logic                  standby
);
   import ofs_pkg::*;

   localparam int ACC_CYC   = `OFS_ACC_CYC;
   localparam int SLEEP_CYC = `OFS_SLEEP_CYC;

   // ==========================================================
   // Pin synchronisation
   // ==========================================================
   logic [23:0] a_s;
   logic [15:0] d_s;
   logic [6:0]  c_s;
   ofs_sync2 #(.W(47)) u_sync (
      .sys_clk (sys_clk),
      .srst    (srst),
      .din     ({addr_pin, data_pins_i, ce_n, oe_n, we_n, reset_n,
                 sync_mode, suspended, burst_step}),
      .dout    ({a_s, d_s, c_s})
   );
   logic ce_s, oe_s, we_s, rst_s, sm_s, sus_s, bs_s;
   assign {ce_s, oe_s, we_s, rst_s, sm_s, sus_s, bs_s} = c_s;

   // ==========================================================
   // Command state machine
   // ==========================================================
   ofs_state_t  st_q, st_d;
   logic [23:0] sect_q, sect_d;
   logic [5:0]  cnt_q, cnt_d;
   logic [5:0]  left_q, left_d;
   logic        we_q, perr_q, perr_d;
   logic [3:0]  busy_q, busy_d;
   ofs_wr_t     wr_q, wr_d;
   logic [7:0]  ba_q, ba_d;
   logic [23:0] la_q;
   logic        wr_stb, ovl_hit, loading;
   logic [11:0] woff;

   // A write is taken on the rising edge of the write strobe while selected.
   assign wr_stb = we_s & ~we_q & ~ce_s;
   assign woff   = a_s[11:0];
   assign ovl_hit = (st_q != OFS_IDLE) && (a_s[23:12] == sect_q[23:12]);
   // A buffered word that equals the exit code is data, not a command.
   assign loading = (st_q == OFS_LOAD) && (left_q != 6'd0);

   always_comb begin
      st_d   = st_q;
      sect_d = sect_q;
      cnt_d  = cnt_q;
      left_d = left_q;
      perr_d = perr_q;
      busy_d = busy_q;
      wr_d   = '0;
      ba_d   = ba_q;
      if (st_q == OFS_BUSY) begin
         // Deselect has no effect here so the program completes unless srst or reset_n resets the state.
         if (busy_q == 4'd0) begin
            st_d = OFS_OVL;
         end else begin
            busy_d = busy_q - 4'd1;
         end
      end else if (wr_stb) begin
         if (d_s == `OFS_CMD_EXIT && st_q != OFS_IDLE && !loading) begin
            st_d = OFS_IDLE;
         end else begin
            unique case (st_q)
               OFS_IDLE: begin
                  if (d_s == `OFS_CMD_ENTRY && woff == `OFS_OFF_UNLOCK) begin
                     st_d   = OFS_OVL;
                     sect_d = a_s;
                     perr_d = 1'b0;
                  end
               end
               OFS_OVL: begin
                  if (d_s == `OFS_CMD_SETUP && woff == `OFS_OFF_UNLOCK) begin
                     st_d = OFS_CNT;
                  end
               end
               OFS_CNT: begin
                  if (woff == `OFS_OFF_COUNT && d_s[15:5] == 11'd0) begin
                     st_d   = OFS_LOAD;
                     cnt_d  = {1'b0, d_s[4:0]} + 6'd1;
                     left_d = {1'b0, d_s[4:0]} + 6'd1;
                  end else begin
                     st_d = OFS_OVL;
                  end
               end
               OFS_LOAD: begin
                  if (left_q != 6'd0) begin
                     left_d = left_q - 6'd1;
                     if (!cust_locked) begin
                        wr_d.we   = 1'b1;
                        wr_d.addr = a_s;
                        wr_d.data = d_s;
                     end
                  end else if (d_s == `OFS_CMD_COMMIT && woff == `OFS_OFF_UNLOCK) begin
                     st_d   = OFS_BUSY;
                     busy_d = 4'(`OFS_PROG_CYC);
                     perr_d = cust_locked;
                  end else begin
                     st_d = OFS_OVL;
                  end
               end
               default: st_d = OFS_OVL;
            endcase
         end
      end
      // Burst address in the overlay wraps inside one 256-word page.
      if (st_q != OFS_IDLE && bs_s) begin
         ba_d = (ba_q + 8'd1) & `OFS_WRAP_MASK;
      end else if (a_s != la_q) begin
         ba_d = a_s[7:0];
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst | ~rst_s) begin
         st_q   <= OFS_IDLE;
         sect_q <= 24'h00_0000;
         cnt_q  <= 6'd0;
         left_q <= 6'd0;
         perr_q <= 1'b0;
         busy_q <= 4'd0;
         wr_q   <= '0;
         ba_q   <= 8'h00;
      end else begin
         st_q   <= st_d;
         sect_q <= sect_d;
         cnt_q  <= cnt_d;
         left_q <= left_d;
         perr_q <= perr_d;
         busy_q <= busy_d;
         wr_q   <= wr_d;
         ba_q   <= ba_d;
      end
   end

   // ==========================================================
   // Power modes and read path
   // ==========================================================
   logic [7:0]  stab_q, stab_d;
   logic [7:0]  acc_q, acc_d;
   logic        sby_q, sby_d;
   logic        slp_q, slp_d;
   logic [15:0] dq_q, dq_d;
   logic [15:0] rdata;

   // Overlay data only for the remapped sector.
   assign rdata = ovl_hit ? overlay_rdata : array_rdata;

   always_comb begin
      stab_d = stab_q;
      acc_d  = acc_q;
      dq_d   = dq_q;
      sby_d  = ce_s & rst_s;
      slp_d  = slp_q;
      // Sleep looks at address stability, sync mode and suspend, never at the strobes.
      if (a_s != la_q) begin
         stab_d = 8'd0;
         slp_d  = 1'b0;
         acc_d  = 8'(ACC_CYC);
      end else if (stab_q < 8'(SLEEP_CYC)) begin
         stab_d = stab_q + 8'd1;
      end else if (!sm_s && !sus_s) begin
         slp_d = 1'b1;
      end
      if (sm_s) begin
         slp_d = 1'b0;
      end else if (sus_s) begin
         slp_d = 1'b0;
      end
      // A new address restarts the access count instead of letting it run down.
      if (sby_q && !sby_d) begin
         acc_d = 8'(ACC_CYC);
      end else if (acc_q != 8'd0 && a_s == la_q) begin
         acc_d = acc_q - 8'd1;
      end
      // In sleep the latch keeps the last word, saving array reads.
      if (!slp_q && acc_q == 8'd1) begin
         dq_d = rdata;
      end
   end

   always_ff @(posedge sys_clk) begin
      if (srst) begin
         stab_q <= 8'd0;
         acc_q  <= 8'd0;
         sby_q  <= 1'b0;
         slp_q  <= 1'b0;
         dq_q   <= 16'h0000;
         la_q   <= 24'h00_0000;
         we_q   <= 1'b1;
      end else begin
         stab_q <= stab_d;
         acc_q  <= acc_d;
         sby_q  <= sby_d;
         slp_q  <= slp_d;
         dq_q   <= dq_d;
         la_q   <= a_s;
         // Held idle during hardware reset, so settling synchronisers fake no write edge.
         we_q   <= we_s | ~rst_s;
      end
   end

   // ==========================================================
   // Outputs
   // ==========================================================
   assign data_pins_o  = dq_q;
   // Drive only when selected, enabled and awake from standby.
   assign data_pins_oe = (sby_q || oe_s || ce_s) ? 16'h0000 : 16'hFFFF;
   // Ready is always driven, never gated by output enable.
   assign ready          = (acc_q == 8'd0);
   assign prog_wr        = wr_q;
   assign overlay_active = (st_q != OFS_IDLE);
   assign overlay_addr   = ba_q;
   assign protect_err    = perr_q;
   assign sleeping       = slp_q;
   assign standby        = sby_q;
endmodule : ofs_seq
`default_nettype wire

// >>> verif/ofs_seq_properties.sv
// Concurrent checks on the ports of the overlay sequencer.
`timescale 1ns/1ps
`default_nettype none
// =========
// Checker
module ofs_seq_props (
   // Clock and reset
   input wire logic             sys_clk,
   input wire logic             srst,
   // Pins and status
   input wire logic             ce_n,
   input wire logic             oe_n,
   input wire logic             reset_n,
   input wire logic             sync_mode,
   input wire logic             suspended,
   input wire logic             cust_locked,
   input wire logic [23:0]      addr_pin,
   input wire logic [15:0]      data_pins_i,
   input wire logic [15:0]      data_pins_o,
   input wire logic [15:0]      data_pins_oe,
   input wire ofs_pkg::ofs_wr_t prog_wr,
   input wire logic             overlay_active,
   input wire logic             sleeping,
   input wire logic             standby
);
   default clocking cb @(posedge sys_clk); endclocking
   default disable iff (srst);
   // Eight quiet cycles just cover the synchronisers, the compare, the sleep count and its register stage.
   sequence s_quiet;
      ($stable(addr_pin) && !sync_mode && !suspended && reset_n)[*8];
   endsequence
   sequence s_deselect;
      (ce_n && reset_n)[*5];
   endsequence
   property p_sleep; s_quiet |-> sleeping; endproperty
   a_sleep: assert property (p_sleep) else $error("no sleep");
   property p_latch; sleeping && $past(sleeping) |-> $stable(data_pins_o); endproperty
   a_latch: assert property (p_latch) else $error("sleep data moved");
   property p_wake; $changed(addr_pin) |-> ##[0:4] !sleeping; endproperty
   a_wake: assert property (p_wake) else $error("no wake");
   property p_sync; sync_mode[*4] |-> !sleeping; endproperty
   a_sync: assert property (p_sync) else $error("sleep in sync");
   property p_susp; suspended[*4] |-> !sleeping; endproperty
   a_susp: assert property (p_susp) else $error("sleep in suspend");
   property p_oe; oe_n[*4] |-> data_pins_oe == 16'h0000; endproperty
   a_oe: assert property (p_oe) else $error("driven with oe off");
   property p_stby; s_deselect |-> standby && data_pins_oe == 16'h0000; endproperty
   a_stby: assert property (p_stby) else $error("no standby");
   property p_entry;
      $rose(overlay_active) |-> data_pins_i == 16'h0088 && addr_pin[11:0] == 12'h555;
   endproperty
   a_entry: assert property (p_entry) else $error("bad entry");
   property p_exit; $fell(overlay_active) |-> data_pins_i == 16'h00F0 || !reset_n; endproperty
   a_exit: assert property (p_exit) else $error("bad exit");
   property p_prog; prog_wr.we |-> overlay_active && !cust_locked; endproperty
   a_prog: assert property (p_prog) else $error("bad program");
endmodule : ofs_seq_props
bind ofs_seq ofs_seq_props i_props (.*);
`default_nettype wire

// >>> verif/ofs_host.sv
// Host model that issues write cycles on the flash bus.
`timescale 1ns/1ps
`default_nettype none
// =========
// Host
module ofs_host (
   // Clock
   input  wire logic        sys_clk,
   // Bus lines
   output logic             ce_n,
   output logic             oe_n,
   output logic             we_n,
   output logic [23:0]      addr_pin,
   output logic [15:0]      data_pins_i
);
   initial begin
      ce_n = 1'b0;
      oe_n = 1'b1;
      we_n = 1'b1;
      addr_pin = 24'h00_0000;
      data_pins_i = 16'h0000;
   end
   // The strobe is long enough for the pin synchronisers; lines hold until taken.
   task automatic wr(input logic [23:0] a, input logic [15:0] d);
      @(negedge sys_clk);
      addr_pin = a;
      data_pins_i = d;
      we_n = 1'b0;
      repeat (3) @(negedge sys_clk);
      we_n = 1'b1;
      repeat (6) @(negedge sys_clk);
      // A released bus must not keep showing the last word.
      data_pins_i = ~d;
   endtask : wr
endmodule : ofs_host
`default_nettype wire

// >>> verif/tb_ofs_seq.sv
// Self-checking bench for the overlay sequencer.
`timescale 1ns/1ps
`default_nettype none
`include "ofs_consts.svh"
// =========
// Bench
module tb_ofs_seq;
   logic sys_clk, srst, ce_n, oe_n, we_n, reset_n, sync_mode, suspended, burst_step;
   logic cust_locked, ready, overlay_active, protect_err, sleeping, standby;
   logic [23:0] addr_pin, last_a;
   logic [15:0] data_pins_i, data_pins_o, data_pins_oe, array_rdata, overlay_rdata, last_d;
   logic [7:0]  overlay_addr, a0;
   ofs_pkg::ofs_wr_t prog_wr;
   int miscompares = 0;
   int checks_done = 0;
   int n_wr = 0;
   ofs_host i_host (.*);
   ofs_seq i_dut (.*);
   initial begin
      sys_clk = 1'b0;
      forever #12.5 sys_clk = ~sys_clk;
   end
   // Sampled mid-cycle, away from the edge that launches the pulse.
   always @(negedge sys_clk) if (prog_wr.we === 1'b1) begin
      n_wr++;
      last_a = prog_wr.addr;
      last_d = prog_wr.data;
   end
   task automatic chk(input logic ok, input string m);
      checks_done++;
      if (ok !== 1'b1) begin
         miscompares++;
         $display("BAD %0t %s", $time, m);
      end
   endtask : chk
   task automatic w(input int n);
      repeat (n) @(negedge sys_clk);
   endtask : w
   task automatic t_entry_exit();
      i_host.wr(24'h01_2555, 16'h0025);
      chk(overlay_active === 1'b0, "entered on other code");
      i_host.wr(24'h01_2555, 16'h0088);
      chk(overlay_active === 1'b1, "no entry");
      i_host.wr(24'hAB_C123, 16'h00F0);
      chk(overlay_active === 1'b0, "no exit");
   endtask : t_entry_exit
   task automatic t_prog(input int n, input logic lk);
      int base;
      int exp;
      base = n_wr;
      exp = (lk || n > 32) ? 0 : n;
      cust_locked = lk;
      i_host.wr(24'h01_2555, 16'h0025);
      i_host.wr(24'h01_22AA, 16'(n - 1));
      for (int i = 0; i < n; i++) i_host.wr(24'h01_2000 + 24'(i), 16'h1000 + 16'(i));
      i_host.wr(24'h01_2555, 16'h0029);
      w(12);
      chk(n_wr - base == exp, "word count");
      if (exp > 0) begin
         chk(last_a === 24'h01_1fff + 24'(n) && last_d === 16'h0fff + 16'(n), "word");
      end
      chk(protect_err === lk && overlay_active === 1'b1, "status");
   endtask : t_prog
   task automatic t_burst_read();
      logic wrapped;
      wrapped = 1'b0;
      i_host.wr(24'h01_2555, 16'h0088);
      a0 = overlay_addr;
      for (int i = 0; i < 256; i++) begin
         burst_step = 1'b1;
         w(1);
         burst_step = 1'b0;
         w(1);
         if (overlay_addr === 8'h00) wrapped = 1'b1;
      end
      // The last step lands three edges after its pulse, past the end of the loop.
      w(2);
      chk(wrapped === 1'b1 && overlay_addr === a0, "no wrap");
      i_host.oe_n = 1'b0;
      array_rdata = 16'h1234;
      overlay_rdata = 16'h4321;
      i_host.addr_pin = 24'h00_0010;
      w(8);
      chk(data_pins_o === 16'h1234, "outside read");
      i_host.addr_pin = 24'h01_2010;
      w(8);
      chk(data_pins_o === 16'h4321, "overlay read");
      reset_n = 1'b0;
      w(6);
      reset_n = 1'b1;
      w(4);
      chk(overlay_active === 1'b0, "reset kept overlay");
   endtask : t_burst_read
   task automatic t_standby();
      int c;
      i_host.ce_n = 1'b1;
      w(8);
      chk(standby === 1'b1 && data_pins_oe === 16'h0000, "standby");
      i_host.ce_n = 1'b0;
      // Two synchroniser stages come first; the edge that clears the standby register also loads the access count.
      w(3);
      chk(ready === 1'b0, "ready at wake");
      c = 3;
      while (ready !== 1'b1 && c < 50) begin
         w(1);
         c++;
      end
      chk(c >= 3 + `OFS_ACC_CYC && c <= 4 + `OFS_ACC_CYC, "ready timing");
      chk(data_pins_oe === 16'hFFFF, "not driving");
      i_host.oe_n = 1'b1;
      w(4);
      chk(data_pins_oe === 16'h0000 && ready === 1'b1, "oe effect");
   endtask : t_standby
   task automatic t_sleep();
      array_rdata = 16'hA5A5;
      i_host.addr_pin = 24'h00_0100;
      w(12);
      chk(sleeping === 1'b1 && data_pins_o === 16'hA5A5, "no sleep");
      array_rdata = 16'h5A5A;
      w(3);
      chk(data_pins_o === 16'hA5A5, "latch lost");
      i_host.addr_pin = 24'h00_0101;
      w(8);
      chk(data_pins_o === 16'h5A5A, "no new data");
      suspended = 1'b1;
      i_host.addr_pin = 24'h00_0102;
      w(12);
      chk(sleeping === 1'b0, "slept in suspend");
      suspended = 1'b0;
      sync_mode = 1'b1;
      i_host.addr_pin = 24'h00_0103;
      w(12);
      chk(sleeping === 1'b0, "slept in sync");
      sync_mode = 1'b0;
   endtask : t_sleep
   task automatic finish_test();
      $display("checks_done %0d miscompares %0d", checks_done, miscompares);
      if (miscompares == 0 && checks_done > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask : finish_test
   initial begin
      repeat (20000) @(posedge sys_clk);
      miscompares++;
      $display("BAD %0t timeout", $time);
      finish_test();
   end
   initial begin
      srst = 1'b1;
      reset_n = 1'b1;
      sync_mode = 1'b0;
      suspended = 1'b0;
      burst_step = 1'b0;
      cust_locked = 1'b0;
      array_rdata = 16'h0000;
      overlay_rdata = 16'h0000;
      w(3);
      srst = 1'b0;
      w(3);
      t_entry_exit();
      i_host.wr(24'h01_2555, 16'h0088);
      t_prog(1, 1'b0);
      t_prog(32, 1'b0);
      t_prog(33, 1'b0);
      t_prog(1, 1'b1);
      cust_locked = 1'b0;
      i_host.wr(24'h00_0000, 16'h00F0);
      t_burst_read();
      t_standby();
      t_sleep();
      finish_test();
   end
endmodule : tb_ofs_seq
`default_nettype wire
